// file: design/txc_pkg.sv
// txc_pkg: constants and types for the transmit power and configuration register bank
package txc_pkg;
  // =========================================
  // register indices (byte address is index times four)
  localparam logic [7:0]  TXC_IDX_TXPWR    = 8'h1C;
  localparam logic [7:0]  TXC_IDX_NVMCTL   = 8'h1F;
  localparam logic [7:0]  TXC_IDX_SUB_A    = 8'h90;  // 144
  localparam logic [7:0]  TXC_IDX_SUB_VREG = 8'h97;  // 151
  localparam logic [7:0]  TXC_IDX_SUB_B    = 8'h99;  // 153
  localparam logic [7:0]  TXC_IDX_SUB_C    = 8'h9B;  // 155
  localparam logic [7:0]  TXC_IDX_SUB_D    = 8'hA5;  // 165
  localparam logic [7:0]  TXC_IDX_SUB_MOD  = 8'hAA;  // 170
  localparam logic [7:0]  TXC_IDX_STATUS   = 8'hC0;  // nvm load status
  localparam logic [11:0] TXC_ADDR_BITS    = 12'hFFC;  // only the byte lane bits are ignored

  // =========================================
  // field positions
  localparam int TXC_PWR_LSB  = 4;
  localparam int TXC_PWR_MSB  = 15;
  localparam int TXC_PWR_EN   = 0;
  localparam int TXC_NVM_TRIG = 4;
  localparam int TXC_MOD_LSB  = 4;
  localparam int TXC_MOD_MSB  = 7;

  // =========================================
  // reset values
  localparam logic [15:0] TXC_RST_TXPWR = 16'h0000;
  localparam logic [7:0]  TXC_RST_SUB   = 8'h00;
  // revision code: arbitrary neutral value
  localparam logic [7:0]  TXC_REVISION  = 8'h10;

  // =========================================
  // timing
  localparam int TXC_CLK_MHZ     = 125;
  localparam int TXC_NVM_LOAD_US = 200;
  localparam int TXC_NVM_CYCLES  = TXC_NVM_LOAD_US * TXC_CLK_MHZ;

  typedef enum logic [1:0] {TXC_NVM_IDLE, TXC_NVM_BUSY, TXC_NVM_DONE} txc_nvm_st_t;

  // byte address of register index
  function automatic logic [11:0] txc_addr(input logic [7:0] idx);
    txc_addr = {2'b00, idx, 2'b00};
  endfunction : txc_addr
endpackage : txc_pkg

// file: design/txc_nvm_loader.sv
// txc_nvm_loader: times the manual nonvolatile load sequence
`timescale 1ns/1ns
module txc_nvm_loader #(
  parameter int LOAD_CYCLES = txc_pkg::TXC_NVM_CYCLES
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                start,
  input  wire logic                trig_level,
  output logic                     busy,
  output logic                     load_pulse
);
  import txc_pkg::*;

  typedef struct packed {
    txc_nvm_st_t st;
    logic [31:0] cnt;
    logic        busy;
    logic        pulse;
  } txc_ld_t;

  txc_ld_t s_q, s_d;

  // =========================================
  // sequence: start -> busy count -> done until trigger negated
  always_comb begin
    s_d       = s_q;
    s_d.pulse = 1'b0;
    case (s_q.st)
      TXC_NVM_IDLE: begin
        if (start) begin
          s_d.st    = TXC_NVM_BUSY;
          s_d.cnt   = 32'(LOAD_CYCLES - 1);
          s_d.busy  = 1'b1;
          s_d.pulse = 1'b1;
        end
      end
      TXC_NVM_BUSY: begin
        if (s_q.cnt == 32'h0) begin
          s_d.st   = TXC_NVM_DONE;
          s_d.busy = 1'b0;
        end else begin
          s_d.cnt = s_q.cnt - 32'h1;
        end
      end
      TXC_NVM_DONE: begin
        if (!trig_level) begin
          s_d.st = TXC_NVM_IDLE;
        end
      end
      default: s_d.st = TXC_NVM_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{TXC_NVM_IDLE, 32'h0, 1'b0, 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign busy       = s_q.busy;
  assign load_pulse = s_q.pulse;
endmodule : txc_nvm_loader

// file: design/txc_regs.sv
// txc_regs: APB register bank for transmit power, nvm load and configuration
//
// Behaviour
// - The power request is 12 bits in 15..4, 1/32 dBm steps from -80 dBm at 0x000.
// - Writing bit 0 of the power register as 1 makes the power request steer the output.
// - Writing 1 to bit 4 of the load register while it holds 0 and no load is busy starts a nonvolatile load.
// - Reading the revision register gives major and minor revision nibbles in bits 7..0.
// - Bits 7..4 of register 170 enable the I, IB, Q and QB modulator channels.
`timescale 1ns/1ns
module txc_regs #(
  parameter int NVM_CYCLES = txc_pkg::TXC_NVM_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [11:0] tx_power_code,
  output logic             tx_power_ctrl_en,
  output logic             nvm_load_start,
  output logic             nvm_load_busy,
  output logic      [7:0]  second_regulator_voltage,
  output logic      [7:0]  reserved_cfg_a,
  output logic      [7:0]  reserved_cfg_b,
  output logic      [7:0]  reserved_cfg_c,
  output logic      [7:0]  reserved_cfg_d,
  output logic      [3:0]  modulator_channel_en
);
  import txc_pkg::*;

  typedef struct packed {
    logic [15:0] txpwr;
    logic        nvm_trig;
    logic [7:0]  sub_a;
    logic [7:0]  vreg;
    logic [7:0]  sub_b;
    logic [7:0]  sub_c;
    logic [7:0]  sub_d;
    logic [7:0]  sub_mod;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic        start;
  } txc_regs_t;

  txc_regs_t r_q, r_d;
  logic      ld_busy;
  logic      ld_pulse;

  // merge a byte lane write into an 8 bit register
  function automatic logic [7:0] txc_wr8(input logic [7:0] old, input logic [31:0] wd,
                                         input logic [3:0] st);
    txc_wr8 = st[0] ? wd[7:0] : old;
  endfunction : txc_wr8

  // merge byte lane writes into a 16 bit register
  function automatic logic [15:0] txc_wr16(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] st);
    txc_wr16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction : txc_wr16

  // address is mapped when it hits one of the registers
  function automatic logic txc_hit(input logic [11:0] a);
    txc_hit = (a == txc_addr(TXC_IDX_TXPWR))    || (a == txc_addr(TXC_IDX_NVMCTL))   ||
              (a == txc_addr(TXC_IDX_SUB_A))    || (a == txc_addr(TXC_IDX_SUB_VREG)) ||
              (a == txc_addr(TXC_IDX_SUB_B))    || (a == txc_addr(TXC_IDX_SUB_C))    ||
              (a == txc_addr(TXC_IDX_SUB_D))    || (a == txc_addr(TXC_IDX_SUB_MOD))  ||
              (a == txc_addr(TXC_IDX_STATUS));
  endfunction : txc_hit

  // =========================================
  // nvm load sequencer
  txc_nvm_loader #(
    .LOAD_CYCLES (NVM_CYCLES)
  ) u_nvm (
    .pclk       (pclk),
    .presetn    (presetn),
    .start      (r_q.start),
    .trig_level (r_q.nvm_trig),
    .busy       (ld_busy),
    .load_pulse (ld_pulse)
  );

  // =========================================
  // apb access: one wait state, answer in the second access cycle
  always_comb begin
    logic        acc;
    logic        wr;
    logic [11:0] a;
    acc     = psel && penable && !r_q.ready;
    wr      = acc && pwrite;
    a       = paddr & TXC_ADDR_BITS;
    r_d       = r_q;
    r_d.ready = acc;
    r_d.err   = acc && !txc_hit(a);
    r_d.start = 1'b0;
    r_d.rdata = 32'h0; // read data stands one cycle, zero on writes and refusals
    if (wr) begin
      if (a == txc_addr(TXC_IDX_TXPWR)) begin
        r_d.txpwr = txc_wr16(r_q.txpwr, pwdata, pstrb);
      end
      if (a == txc_addr(TXC_IDX_NVMCTL) && pstrb[0]) begin
        r_d.nvm_trig = pwdata[TXC_NVM_TRIG];
        r_d.start    = pwdata[TXC_NVM_TRIG] && !r_q.nvm_trig;
      end
      if (a == txc_addr(TXC_IDX_SUB_A)) begin
        r_d.sub_a = txc_wr8(r_q.sub_a, pwdata, pstrb);
      end
      if (a == txc_addr(TXC_IDX_SUB_VREG)) begin
        r_d.vreg = txc_wr8(r_q.vreg, pwdata, pstrb);
      end
      if (a == txc_addr(TXC_IDX_SUB_B)) begin
        r_d.sub_b = txc_wr8(r_q.sub_b, pwdata, pstrb);
      end
      if (a == txc_addr(TXC_IDX_SUB_C)) begin
        r_d.sub_c = txc_wr8(r_q.sub_c, pwdata, pstrb);
      end
      if (a == txc_addr(TXC_IDX_SUB_D)) begin
        r_d.sub_d = txc_wr8(r_q.sub_d, pwdata, pstrb);
      end
      if (a == txc_addr(TXC_IDX_SUB_MOD)) begin
        r_d.sub_mod = txc_wr8(r_q.sub_mod, pwdata, pstrb);
      end
    end
    // readback: write-only registers read as zero
    if (acc && !pwrite) begin
      if (a == txc_addr(TXC_IDX_NVMCTL)) begin
        r_d.rdata = {24'h0, TXC_REVISION};
      end
      if (a == txc_addr(TXC_IDX_STATUS)) begin
        r_d.rdata = {30'h0, r_q.nvm_trig, ld_busy};
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '{TXC_RST_TXPWR, 1'b0, TXC_RST_SUB, TXC_RST_SUB, TXC_RST_SUB, TXC_RST_SUB,
               TXC_RST_SUB, TXC_RST_SUB, 32'h0, 1'b0, 1'b0, 1'b0};
    end else begin
      r_q <= r_d;
    end
  end

  // outputs straight from flip-flops
  assign prdata                   = r_q.rdata;
  assign pready                   = r_q.ready;
  assign pslverr                  = r_q.err;
  assign tx_power_code            = r_q.txpwr[TXC_PWR_MSB:TXC_PWR_LSB];
  assign tx_power_ctrl_en         = r_q.txpwr[TXC_PWR_EN];
  assign nvm_load_start           = ld_pulse;
  assign nvm_load_busy            = ld_busy;
  assign second_regulator_voltage = r_q.vreg;
  assign reserved_cfg_a           = r_q.sub_a;
  assign reserved_cfg_b           = r_q.sub_b;
  assign reserved_cfg_c           = r_q.sub_c;
  assign reserved_cfg_d           = r_q.sub_d;
  assign modulator_channel_en     = r_q.sub_mod[TXC_MOD_MSB:TXC_MOD_LSB];
endmodule : txc_regs

// file: tb/txc_regs_sva.sv
// txc_regs_sva: bus and register assertions for the register bank
`timescale 1ns/1ns
module txc_regs_sva import txc_pkg::*; #(parameter int NVM_CYCLES = 20) (
  input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr, tx_power_code,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [3:0]  pstrb, modulator_channel_en,
  input wire logic        tx_power_ctrl_en, nvm_load_start, nvm_load_busy
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // request taken in the access cycle
  wire tk = psel && penable && !pready;
  logic [31:0] cnt_q;
  // counts how long the load stays busy
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) cnt_q <= '0;
    else cnt_q <= nvm_load_busy ? cnt_q + 32'd1 : '0;
  a_ready_one_wait: assert property (tk |=> pready) else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_err_no_data: assert property (pslverr |-> pready && prdata == '0) else $error("bad error");
  a_unmapped_err: assert property (tk && paddr == 12'h3FC |=> pslverr) else $error("no error");
  a_power_write: assert property (tk && pwrite && paddr == 12'h070 && pstrb == 4'hF |=>
    tx_power_code == $past(pwdata[15:4]) && tx_power_ctrl_en == $past(pwdata[0]))
    else $error("power not taken");
  a_rev_read: assert property (tk && !pwrite && paddr == 12'h07C |=>
    prdata[7:0] == TXC_REVISION) else $error("revision wrong");
  a_mod_write: assert property (tk && pwrite && paddr == 12'h2A8 && pstrb[0] |=>
    modulator_channel_en == $past(pwdata[7:4])) else $error("modulator enables wrong");
  a_start_pulse: assert property (nvm_load_start |=> !nvm_load_start && nvm_load_busy)
    else $error("start pulse wrong");
  a_busy_length: assert property ($fell(nvm_load_busy) |-> cnt_q == NVM_CYCLES)
    else $error("busy length wrong");
endmodule : txc_regs_sva

// file: tb/txc_host.sv
// txc_host: apb master standing in for the host controller
`timescale 1ns/1ns
module txc_host (
  input  wire logic        pclk,
  output logic             psel, penable, pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready, pslverr
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  end
  // one transfer: setup, access held until pready, then release
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] r, output logic e);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable, paddr, pwdata} <= {2'b00, ~a, ~d};
  endtask : xfer
endmodule : txc_host

// file: tb/tx_power_and_config_registers_test.sv
// tx_power_and_config_registers_test: self-checking bench for the register bank
`timescale 1ns/1ns
module tx_power_and_config_registers_test;
  import txc_pkg::*;
  localparam int NC = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, er, trig, tx_power_ctrl_en;
  logic nvm_load_start, nvm_load_busy;
  logic [11:0] paddr, tx_power_code;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, modulator_channel_en;
  logic [7:0] second_regulator_voltage, reserved_cfg_a, reserved_cfg_b, reserved_cfg_c;
  logic [7:0] reserved_cfg_d;
  logic [31:0] m[int];
  int errors = 0, total_checks = 0, cyc = 0, starts = 0, busy_n = 0, exp_st = 0;
  int maps[$] = '{'h070, 'h07C, 'h240, 'h25C, 'h264, 'h26C, 'h294, 'h2A8, 'h300};
  int sub[$] = '{'h240, 'h25C, 'h264, 'h26C, 'h294, 'h2A8, 'h25C};
  int subv[$] = '{'h06, 'hE0, 'h85, 'h78, 'h20, 'hF0, 'h6F};
  txc_regs #(.NVM_CYCLES(NC)) dut_u (.*);
  txc_host host_u (.*);
  initial forever #4 pclk = ~pclk;
  // counts load pulses and busy cycles, and cuts a hang short
  always @(posedge pclk) begin
    cyc++;
    starts += (nvm_load_start === 1'b1);
    busy_n += (nvm_load_busy === 1'b1);
    if (cyc > 6000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  // write through the host and mirror lanes into the model
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    host_u.xfer(1'b1, a, d, s, rd, er);
    chk(er, !(a inside {maps}), "wr err");
    if (a inside {maps})
      for (int i = 0; i < 4; i++) if (s[i]) m[a][8*i+:8] = d[8*i+:8];
    if (a == 12'h07C && s[0]) begin
      if (d[4] && !trig) exp_st++;
      trig = d[4];
    end
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    host_u.xfer(1'b0, a, $urandom, 4'h0, rd, er);
    chk(rd, exp, "read");
    chk(er, !(a inside {maps}), "rd err");
  endtask : rdc
  task automatic outs();
    chk(tx_power_code, m['h070][15:4], "code");
    chk(tx_power_ctrl_en, m['h070][0], "en");
    chk(second_regulator_voltage, m['h25C][7:0], "vreg");
    chk(reserved_cfg_a, m['h240][7:0], "a");
    chk(reserved_cfg_b, m['h264][7:0], "b");
    chk(reserved_cfg_c, m['h26C][7:0], "c");
    chk(reserved_cfg_d, m['h294][7:0], "d");
    chk(modulator_channel_en, m['h2A8][7:4], "mod");
  endtask : outs
  // main sequence
  initial begin
    void'($urandom(42767));
    trig = 1'b0;
    foreach (maps[i]) m[maps[i]] = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    outs();
    // span ends 0x000 and 0xB40, then repeated random requests within the valid span
    for (int k = 0; k < 5; k++) begin
      wr(12'h070, {k == 1 ? 12'hB40 : k ? 12'($urandom_range(0, 'hB40)) : 12'h0, 3'b0, k[0]});
      outs();
      rdc(12'h070, '0);
    end
    wr(12'h070, $urandom, 4'h1);
    outs();
    // configuration values for normal operation, then random words
    foreach (sub[i]) begin
      wr(sub[i], subv[i]);
      outs();
    end
    repeat (6) begin
      wr(sub[$urandom_range(0, 5)], $urandom);
      outs();
    end
    rdc(12'h2A8, '0);
    // load trigger, no re-arm without clearing, then a second load
    for (int k = 0; k < 2; k++) begin
      wr(12'h07C, 32'h10);
      rdc(12'h07C, {24'h0, TXC_REVISION});
      repeat (NC + 4) @(posedge pclk);
      wr(12'h07C, 32'h10);
      wr(12'h07C, 32'h0);
    end
    chk(starts, exp_st, "starts");
    chk(busy_n, exp_st * NC, "busy");
    // unmapped place refuses and leaves state alone
    wr(12'h3FC, $urandom);
    rdc(12'h3FC, '0);
    outs();
    // second reset clears everything
    presetn <= 1'b0;
    trig = 1'b0;
    foreach (maps[i]) m[maps[i]] = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    outs();
    end_of_test();
  end
endmodule : tx_power_and_config_registers_test
bind txc_regs txc_regs_sva #(.NVM_CYCLES(NVM_CYCLES)) chk_u (.*);
